// ---- rtl/tocu_pkg.sv ----
// Constants for the two-channel timer output compare unit
package tocu_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_CTL1 = 6'h20; // timer_control_one
  localparam logic [5:0] IDX_CTL2 = 6'h21; // timer_control_two
  localparam logic [5:0] IDX_STAT = 6'h22; // timer_status_reg
  localparam logic [5:0] IDX_CNTH = 6'h23; // Counter high byte
  localparam logic [5:0] IDX_CNTL = 6'h24; // counter_low_byte
  localparam logic [5:0] IDX_ACNTH = 6'h25; // Alternate counter high
  localparam logic [5:0] IDX_ACNTL = 6'h26; // alt_counter_low_byte
  localparam logic [5:0] IDX_CMP1H = 6'h27; // Channel 1 compare high
  localparam logic [5:0] IDX_CMP1L = 6'h28; // Channel 1 compare low
  localparam logic [5:0] IDX_CMP2H = 6'h29; // Channel 2 compare high
  localparam logic [5:0] IDX_CMP2L = 6'h2A; // Channel 2 compare low
  // Control one field positions
  localparam int CTL1_LVL1 = 0;
  localparam int CTL1_LVL2 = 2;
  localparam int CTL1_FRC1 = 3;
  localparam int CTL1_FRC2 = 4;
  localparam int CTL1_OVIE = 5;
  localparam int CTL1_CMPIE = 6;
  localparam logic [7:0] CTL1_MASK = 8'h7D; // Writable bits
  // Control two field positions
  localparam int CTL2_CKSEL = 2; // Low bit of timer_clock_select
  localparam int CTL2_PEN2 = 6;
  localparam int CTL2_PEN1 = 7;
  localparam logic [7:0] CTL2_MASK = 8'hCC;
  // Status field positions
  localparam int STAT_F2 = 3;
  localparam int STAT_OVF = 5;
  localparam int STAT_F1 = 6;
  // Reset values
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Clock select codes and prescaler terminal counts
  typedef enum logic [1:0] {
    TOCU_CK_DIV4 = 2'b00,
    TOCU_CK_DIV2 = 2'b01,
    TOCU_CK_DIV8 = 2'b10,
    TOCU_CK_EXT = 2'b11
  } tocu_cksel_t;
  localparam logic [2:0] PRE_LAST_DIV2 = 3'h1;
  localparam logic [2:0] PRE_LAST_DIV4 = 3'h3;
  localparam logic [2:0] PRE_LAST_DIV8 = 3'h7;
endpackage

// ---- rtl/tocu_top.sv ----
// Two-channel output compare timer with APB register slave
// What this block does
// - Compare equal to counter sets match flag
// - Full 16-bit compare once per timer clock
// - Compare registers reset to 8000h
// - Compare registers software owned, hardware untouched
// - Enabled pin takes level; latch low at reset
// - Compare irq needs enable and clear mask
// - Flag clears: status read, then low-byte access
// - High-byte write inhibits compare until low write
// - Pin disabled: no level, irq still possible
// - Divide by 2 equal; otherwise equal plus one
// - Force copies level; no flag, no irq
// - WAIT: timer runs, enabled irq wakes
// - HALT freezes counter; reset restarts at reload
// - Timer events wake WAIT, never HALT
// - One shared irq line, one compare enable, one overflow enable
// - Counter steps at CPU clock over 2/4/8
// - Overflow flag on FFFFh to 0000h wrap
// - Counter resets and reloads only FFFCh
// - Clock select 00 /4, 01 /2, 10 /8
// - Overflow clear via low byte, not alternate
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module tocu_top
  import tocu_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CPU_IRQ_MASK,
  input wire logic WAIT_MODE,
  input wire logic HALT_MODE,
  input wire logic EXT_TICK,
  output logic TIMER_IRQ,
  output logic WAIT_WAKE,
  output logic CMP1_PIN,
  output logic CMP1_PIN_EN,
  output logic CMP2_PIN,
  output logic CMP2_PIN_EN
);

  // Software-visible and internal state
  logic [7:0] ctl1_r; // Control one
  logic [7:0] ctl2_r; // Control two
  logic [15:0] cmp1_r; // Channel 1 compare value
  logic [15:0] cmp2_r; // Channel 2 compare value
  logic [15:0] cnt_r; // Free-running counter
  logic [2:0] pre_r; // Prescaler
  logic flag1_r, flag2_r, ovf_r; // Sticky event flags
  logic arm1_r, arm2_r, armo_r; // First clear step seen
  logic inh1_r, inh2_r; // Compare inhibited after high write
  logic fresh_r; // Counter holds a value not yet compared
  logic [7:0] lowbuf_r; // Buffered low byte of a 16-bit read
  logic lowpend_r; // High byte read, low byte still due
  logic pin1_r, pin2_r; // Output latches
  logic irq_r, wake_r, pready_r, perr_r;
  logic [31:0] prdata_r;

  // Bus phase decode
  wire setup = PSEL & ~PENABLE;
  wire rd_go = setup & ~PWRITE; // Read side effects at setup edge
  wire wr_go = PSEL & PENABLE & pready_r & PWRITE;
  wire [5:0] idx = PADDR[7:2];
  wire mapped = (idx >= IDX_CTL1) && (idx <= IDX_CMP2L);
  wire acc_go = rd_go | wr_go;
  wire wr_ctl1 = wr_go && idx == IDX_CTL1;
  wire wr_ctl2 = wr_go && idx == IDX_CTL2;
  wire wr_c1h = wr_go && idx == IDX_CMP1H;
  wire wr_c1l = wr_go && idx == IDX_CMP1L;
  wire wr_c2h = wr_go && idx == IDX_CMP2H;
  wire wr_c2l = wr_go && idx == IDX_CMP2L;
  wire acc_c1l = acc_go && idx == IDX_CMP1L;
  wire acc_c2l = acc_go && idx == IDX_CMP2L;
  wire acc_cl = acc_go && idx == IDX_CNTL;
  wire rd_stat = rd_go && idx == IDX_STAT;
  wire rd_hi = rd_go && (idx == IDX_CNTH || idx == IDX_ACNTH);
  wire rd_lo = rd_go && (idx == IDX_CNTL || idx == IDX_ACNTL);
  // Either counter low byte write restarts the count
  wire cnt_load = wr_go && (idx == IDX_CNTL || idx == IDX_ACNTL);

  // Field decode
  wire [1:0] cksel = ctl2_r[CTL2_CKSEL +: 2];
  wire pen1 = ctl2_r[CTL2_PEN1];
  wire pen2 = ctl2_r[CTL2_PEN2];
  wire frc1 = ctl1_r[CTL1_FRC1];
  wire frc2 = ctl1_r[CTL1_FRC2];
  wire lvl1 = ctl1_r[CTL1_LVL1];
  wire lvl2 = ctl1_r[CTL1_LVL2];
  wire cmpie = ctl1_r[CTL1_CMPIE];
  wire ovie = ctl1_r[CTL1_OVIE];

  // Prescaler terminal count per clock select
  wire [2:0] pre_last = (cksel == TOCU_CK_DIV2) ? PRE_LAST_DIV2 :
                        (cksel == TOCU_CK_DIV4) ? PRE_LAST_DIV4 :
                        PRE_LAST_DIV8;
  // Reserved code is treated as the external tick input
  wire pre_end = (cksel == TOCU_CK_EXT) ? EXT_TICK : (pre_r == pre_last);
  wire tick = pre_end & ~HALT_MODE;
  // A reload write wins over the step, so no false wrap is flagged
  wire wrap = tick && !cnt_load && cnt_r == 16'hFFFF;

  // Slow clocks see the match one count late, hence the plus one
  wire late = (cksel != TOCU_CK_DIV2);
  wire [15:0] tgt1 = late ? cmp1_r + 16'h0001 : cmp1_r;
  wire [15:0] tgt2 = late ? cmp2_r + 16'h0001 : cmp2_r;
  // One full 16-bit compare per counter value
  wire hit1 = fresh_r & ~inh1_r & (cnt_r == tgt1);
  wire hit2 = fresh_r & ~inh2_r & (cnt_r == tgt2);
  // A forced channel neither flags nor interrupts
  wire set1 = hit1 & ~frc1;
  wire set2 = hit2 & ~frc2;

  // Clear steps; the set term below wins a same-cycle clash
  wire clr1 = arm1_r & acc_c1l;
  wire clr2 = arm2_r & acc_c2l;
  wire clro = armo_r & acc_cl;

  // Read mux over the whole map; unmapped reads give zero
  wire [7:0] stat_v = {1'b0, flag1_r, ovf_r, 1'b0, flag2_r, 3'b000};
  wire [7:0] lo_v = lowpend_r ? lowbuf_r : cnt_r[7:0];
  logic [7:0] rd_v;
  always_comb begin
    case (idx)
      IDX_CTL1: rd_v = ctl1_r;
      IDX_CTL2: rd_v = ctl2_r;
      IDX_STAT: rd_v = stat_v;
      IDX_CNTH: rd_v = cnt_r[15:8];
      IDX_CNTL: rd_v = lo_v;
      IDX_ACNTH: rd_v = cnt_r[15:8];
      IDX_ACNTL: rd_v = lo_v;
      IDX_CMP1H: rd_v = cmp1_r[15:8];
      IDX_CMP1L: rd_v = cmp1_r[7:0];
      IDX_CMP2H: rd_v = cmp2_r[15:8];
      IDX_CMP2L: rd_v = cmp2_r[7:0];
      default: rd_v = 8'h00;
    endcase
  end

  // Bus answer: ready comes one edge after setup, so no wait states
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pready_r <= 1'b0;
      perr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      perr_r <= setup & ~mapped;
      if (rd_go) begin
        prdata_r <= {24'h00_0000, rd_v};
      end
    end
  end

  // Control registers; reserved bits stay zero
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctl1_r <= CTL_RESET;
      ctl2_r <= CTL_RESET;
    end else begin
      if (wr_ctl1) begin
        ctl1_r <= PWDATA[7:0] & CTL1_MASK;
      end
      if (wr_ctl2) begin
        ctl2_r <= PWDATA[7:0] & CTL2_MASK;
      end
    end
  end

  // Compare registers change only by software writes
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cmp1_r <= CMP_RESET;
      cmp2_r <= CMP_RESET;
    end else begin
      if (wr_c1h) begin
        cmp1_r[15:8] <= PWDATA[7:0];
      end
      if (wr_c1l) begin
        cmp1_r[7:0] <= PWDATA[7:0];
      end
      if (wr_c2h) begin
        cmp2_r[15:8] <= PWDATA[7:0];
      end
      if (wr_c2l) begin
        cmp2_r[7:0] <= PWDATA[7:0];
      end
    end
  end

  // Inhibit spans from a high-byte write to the matching low write
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      inh1_r <= 1'b0;
      inh2_r <= 1'b0;
    end else begin
      inh1_r <= wr_c1h | (inh1_r & ~wr_c1l);
      inh2_r <= wr_c2h | (inh2_r & ~wr_c2l);
    end
  end

  // Prescaler and counter; in HALT both hold their value unless a counter low-byte write reloads them
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pre_r <= 3'h0;
      cnt_r <= CNT_RELOAD;
      fresh_r <= 1'b1;
    end else if (cnt_load) begin
      pre_r <= 3'h0;
      cnt_r <= CNT_RELOAD;
      fresh_r <= 1'b1;
    end else begin
      if (!HALT_MODE) begin
        pre_r <= pre_end ? 3'h0 : pre_r + 3'h1;
      end
      if (tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      fresh_r <= tick;
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      flag1_r <= 1'b0;
      flag2_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      flag1_r <= set1 | (flag1_r & ~clr1);
      flag2_r <= set2 | (flag2_r & ~clr2);
      ovf_r <= wrap | (ovf_r & ~clro);
    end
  end

  // First clear step: status read seen while the flag stood
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      arm1_r <= 1'b0;
      arm2_r <= 1'b0;
      armo_r <= 1'b0;
    end else begin
      arm1_r <= (rd_stat & flag1_r) | (arm1_r & ~acc_c1l);
      arm2_r <= (rd_stat & flag2_r) | (arm2_r & ~acc_c2l);
      armo_r <= (rd_stat & ovf_r) | (armo_r & ~acc_cl);
    end
  end

  // Low byte is frozen by a high-byte read until a low-byte read
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lowbuf_r <= 8'h00;
      lowpend_r <= 1'b0;
    end else begin
      if (rd_hi && !lowpend_r) begin
        lowbuf_r <= cnt_r[7:0];
      end
      lowpend_r <= rd_hi | (lowpend_r & ~rd_lo);
    end
  end

  // Pins change on a qualifying match or while forced, else hold
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin1_r <= 1'b0;
      pin2_r <= 1'b0;
    end else begin
      if (pen1 && (frc1 || hit1)) begin
        pin1_r <= lvl1;
      end
      if (pen2 && (frc2 || hit2)) begin
        pin2_r <= lvl2;
      end
    end
  end

  // One shared level request; WAIT wake only outside HALT
  wire irq_nxt = ~CPU_IRQ_MASK &
                 ((cmpie & (flag1_r | flag2_r)) | (ovie & ovf_r));
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      wake_r <= irq_nxt & WAIT_MODE & ~HALT_MODE;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = perr_r;
  assign TIMER_IRQ = irq_r;
  assign WAIT_WAKE = wake_r;
  assign CMP1_PIN = pin1_r;
  assign CMP2_PIN = pin2_r;
  assign CMP1_PIN_EN = ctl2_r[CTL2_PEN1]; // Alternate function select
  assign CMP2_PIN_EN = ctl2_r[CTL2_PEN2];

  // Checks
  AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!NRST)
    set1 |=> flag1_r) else $error("match did not set flag 1");
  AST_CMP_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    !wr_c1h && !wr_c1l |=> $stable(cmp1_r))
    else $error("compare 1 changed without a write");
  AST_RESET_CMP: assert property (@(posedge CLK)
    !NRST |=> cmp2_r == 16'h8000 && cnt_r == 16'hFFFC)
    else $error("wrong reset values");
  AST_INHIBIT: assert property (@(posedge CLK) disable iff (!NRST)
    wr_c1h ##1 !wr_c1l |=> !hit1) else $error("match while inhibited");
  AST_CLEAR: assert property (@(posedge CLK) disable iff (!NRST)
    flag1_r && !arm1_r && !set1 |=> flag1_r)
    else $error("flag 1 cleared without status read");
  AST_FORCE: assert property (@(posedge CLK) disable iff (!NRST)
    frc1 && pen1 |=> pin1_r == $past(lvl1))
    else $error("forced pin does not follow level");
  AST_NOPIN: assert property (@(posedge CLK) disable iff (!NRST)
    !pen1 |=> $stable(pin1_r)) else $error("disabled pin changed");
  AST_IRQ: assert property (@(posedge CLK) disable iff (!NRST)
    CPU_IRQ_MASK |=> !TIMER_IRQ) else $error("irq while masked");
  AST_HALT: assert property (@(posedge CLK) disable iff (!NRST)
    HALT_MODE && !cnt_load |=> $stable(cnt_r))
    else $error("counter moved in halt");
  AST_WRAP: assert property (@(posedge CLK) disable iff (!NRST)
    wrap |=> ovf_r && cnt_r == 16'h0000) else $error("wrap not flagged");
  AST_DIV2: assert property (@(posedge CLK) disable iff (!NRST)
    tick && cksel == 2'b01 && !wr_ctl2 ##1
    !cnt_load && !wr_ctl2 && !HALT_MODE ##1 !HALT_MODE |-> tick)
    else $error("divide by 2 step missed");
  COV_MATCH: cover property (@(posedge CLK) disable iff (!NRST)
    set1 ##[1:20] clr1);
  COV_WRAP: cover property (@(posedge CLK) disable iff (!NRST) wrap);
  COV_FORCE: cover property (@(posedge CLK) disable iff (!NRST)
    frc1 && pen1 && lvl1 ##1 pin1_r);

endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the two-channel output compare timer
`timescale 1ns/1ps
module testbench
  import tocu_pkg::*;
();
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic mask, wt, hlt, tick, irq, wake, p1, p1e, p2, p2e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] cnt; // Counter sample for rate checks
  int errors, n_tests;
  // Reset table: index and expected value
  logic [5:0] ridx [7] = '{IDX_STAT, IDX_CTL1, IDX_CTL2, IDX_CMP1H,
    IDX_CMP1L, IDX_CMP2H, IDX_CMP2L};
  logic [7:0] rexp [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80,
    8'h00};
  logic [1:0] sel [3] = '{2'b01, 2'b00, 2'b10}; // Clock select codes
  int dv [3] = '{2, 4, 8}; // Matching divide factors

  tocu_top tocu_top_i (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_IRQ_MASK(mask), .WAIT_MODE(wt), .HALT_MODE(hlt),
    .EXT_TICK(tick), .TIMER_IRQ(irq), .WAIT_WAKE(wake), .CMP1_PIN(p1),
    .CMP1_PIN_EN(p1e), .CMP2_PIN(p2), .CMP2_PIN_EN(p2e));
  tocu_cpu_model tocu_cpu_model_i (.clk(clk), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Value compare; case inequality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Window compare for counts whose phase is not pinned down
  task automatic chk_rng(input logic [15:0] got, input int lo, hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("[ERR] %0t count %h outside window", $time, got);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [31:0] r;
    tocu_cpu_model_i.xfer(1'b1, idx, v, r, e);
  endtask
  task automatic get(input logic [5:0] idx);
    tocu_cpu_model_i.xfer(1'b0, idx, 8'h00, d, e);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    get(idx);
    chk(d, exp);
  endtask
  // External counter steps, then settle past flag and irq latency
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (5) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog after 10000 cycles; whole sequence needs well under 2000
  initial begin
    #200000;
    errors++;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    mask = 1'b0;
    wt = 1'b0;
    hlt = 1'b0;
    tick = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk({p1, p2, p1e, p2e, irq}, 32'h0);
    foreach (ridx[i]) rd(ridx[i], {24'h0, rexp[i]});
    rd(6'h10, 32'h0);
    chk(e, 32'h1);
    wr(IDX_CTL1, 8'hFF);
    rd(IDX_CTL1, {24'h0, CTL1_MASK});
    // External tick mode: counter moves only when told
    wr(IDX_CTL1, 8'h41);
    wr(IDX_CTL2, 8'hCC);
    wr(IDX_CMP1H, 8'hFF);
    wr(IDX_CMP1L, 8'hFE);
    wr(IDX_CMP2H, 8'h00);
    get(IDX_STAT);
    wr(IDX_CNTL, 8'h00);
    pulse(2);
    rd(IDX_STAT, 32'h0);
    rd(IDX_ACNTH, 32'hFF);
    rd(IDX_ACNTL, 32'hFE);
    pulse(1);
    chk({p1e, p1, irq, p2e, p2}, 32'h1E);
    mask <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    mask <= 1'b0;
    wt <= 1'b1;
    repeat (3) @(posedge clk);
    chk({irq, wake}, 32'h3);
    hlt <= 1'b1;
    pulse(3);
    chk(wake, 32'h0);
    hlt <= 1'b0;
    wt <= 1'b0;
    pulse(2);
    rd(IDX_CMP1L, 32'hFE);
    rd(IDX_ACNTH, 32'h0);
    rd(IDX_ACNTL, 32'h1);
    rd(IDX_STAT, 32'h60);
    rd(IDX_CMP1L, 32'hFE);
    rd(IDX_STAT, 32'h20);
    chk(irq, 32'h0);
    rd(IDX_CNTH, 32'h0);
    rd(IDX_CNTL, 32'h1);
    rd(IDX_STAT, 32'h0);
    wr(IDX_CMP2L, 8'h10);
    rd(IDX_CMP2H, 32'h0);
    rd(IDX_CMP2L, 32'h10);
    // Forced output: level toggled by software, no flag
    for (int v = 0; v < 2; v++) begin
      wr(IDX_CTL1, 8'h08 | 8'(v));
      repeat (3) @(posedge clk);
      chk(p1, v);
    end
    // Match while forced: must leave the flag clear
    wr(IDX_CMP1H, 8'h00);
    wr(IDX_CMP1L, 8'h01);
    pulse(1);
    wr(IDX_CTL1, 8'h00);
    repeat (3) @(posedge clk);
    chk({p1, irq}, 32'h2);
    rd(IDX_STAT, 32'h0);
    wr(IDX_CTL2, 8'h0C);
    @(posedge clk);
    chk(p1e, 32'h0);
    // Prescaler rates: steps seen after a fixed span from reload
    foreach (sel[i]) begin
      wr(IDX_CTL2, {4'h0, sel[i], 2'b00});
      get(IDX_STAT);
      wr(IDX_CNTL, 8'h00);
      repeat (64) @(posedge clk);
      get(IDX_CNTH);
      cnt[15:8] = d[7:0];
      get(IDX_CNTL);
      cnt[7:0] = d[7:0];
      chk_rng(cnt - 16'hFFFC, 64 / dv[i] - 1, 64 / dv[i] + 1);
      get(IDX_STAT);
      chk(d & 32'h20, 32'h20);
    end
    wr(IDX_CTL1, 8'h20);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    // Mid-run reset: counter and compares return to reset values
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(IDX_CNTH, 32'hFF);
    rd(IDX_CMP1L, 32'h0);
    chk(irq, 32'h0);
    complete_run;
  end
endmodule

// ---- verif/tocu_cpu_model.sv ----
// Register bus master standing in for the CPU core
`timescale 1ns/1ps
module tocu_cpu_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Setup, then access held until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [5:0] idx,
      input logic [7:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Wait for ready however long; only the bench watchdog ends it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is scrambled so nothing leans on stale values
    pwdata <= ~{24'h0, wd};
  endtask
endmodule
